// File: verilog/iesl_pkg.sv
// Package: register map, field layout, reset values and bus types of the enable/status block
package iesl_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int         ADR_W          = 8;
	localparam logic [7:0] OFS_ENABLE_LOW = 8'h00;
	localparam logic [7:0] OFS_ACTIVE_LOW = 8'h04;
	localparam logic [7:0] OFS_ENABLE_MID = 8'h08;
	localparam logic [7:0] OFS_ACTIVE_MID = 8'h0C;
	localparam logic [7:0] OFS_VECTOR     = 8'h10;

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int          REG_W         = 16;
	localparam int          REQ_W         = 32;
	localparam int          IDX_W         = 5;
	localparam int          UNUSED_BIT    = 0;
	localparam int          MID_BASE      = 16;
	localparam int          VEC_VALID_BIT = 8;
	localparam logic [15:0] ENABLE_RST    = 16'hFFFF;
	localparam logic [7:0]  VECTOR_BASE   = 8'h10;
	localparam logic [7:0]  VECTOR_LAST   = 8'h3F;

	// ****************************************
	// Bus types
	// ****************************************
	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [ADR_W-1:0] adr;
		logic [3:0]       sel;
		logic [31:0]      dat;
	} iesl_wb_req_s;

	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} iesl_bus_state_e;

endpackage

// File: verilog/iesl_prio_enc.sv
// Fixed-priority encoder: highest set bit of the pending word wins
`timescale 1ns/100ps
module iesl_prio_enc #(
	parameter int WIDTH = 32,
	parameter int IDX_W = 5
) (
	input  wire logic [WIDTH-1:0] pending_i,
	output logic                  found_o,
	output logic [IDX_W-1:0]      index_o
);

	// ****************************************
	// Priority chain, ascending so later bits override
	// ****************************************
	logic [IDX_W-1:0] chain_idx [WIDTH:0];
	logic [WIDTH:0]   chain_hit;

	assign chain_idx[0] = '0;
	assign chain_hit[0] = 1'b0;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_chain
			assign chain_idx[g+1] = pending_i[g] ? IDX_W'(g) : chain_idx[g];
			assign chain_hit[g+1] = pending_i[g] | chain_hit[g];
		end
	endgenerate

	assign found_o = chain_hit[WIDTH];
	assign index_o = chain_idx[WIDTH];

endmodule

// File: verilog/iesl_enable_status.sv
// Enable and status registers for maskable requests 1 to 31, with Wishbone slave
//
// The Wishbone register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
// ****************************************
// How it works
// ****************************************
// How it works
// - The low enable register is 16 bits, read and write, bits 15..1 enable requests 15..1.
// - At reset the low enable register holds all ones, so every low request is enabled.
// - Bit 0 of the low enable register belongs to unused request 0 and affects nothing.
// - The middle enable register is 16 bits, read and write, resets to ones, gates 31..16.
// - An enable bit of one lets its request through and zero blocks it.
// - The low status register is read-only and shows request lines 15..1 on bits 15..1.
// - Status shows the raw line whatever the enable, so a blocked active request reads one.
// - Bit 0 of the low status register always reads zero.
// - The middle status register is read-only and shows requests 31..16 on bits 15..0.
// - A status bit reads one while its source requests and zero while it is idle.
// - Requests are levels and are never latched; they show only while held.
// - Only active and enabled requests compete for the vector, 10h plus the request number.
module iesl_enable_status (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire iesl_pkg::iesl_wb_req_s wb_i,
	input  wire logic [31:0]           req_i,
	output logic                       wb_ack_o,
	output logic [31:0]                wb_dat_o,
	output logic                       irq_request_o,
	output logic [7:0]                 irq_vector_o
);

	// ****************************************
	// State
	// ****************************************
	iesl_pkg::iesl_bus_state_e       bus_state;
	iesl_pkg::iesl_bus_state_e       next_bus_state;
	logic [iesl_pkg::REG_W-1:0]      source_enable_low;
	logic [iesl_pkg::REG_W-1:0]      source_enable_mid;
	logic [iesl_pkg::REG_W-1:0]      next_source_enable_low;
	logic [iesl_pkg::REG_W-1:0]      next_source_enable_mid;
	logic                            ack;
	logic                            next_ack;
	logic [31:0]                     rd_data;
	logic [31:0]                     next_rd_data;
	logic [iesl_pkg::REQ_W-1:0]      req_seen;
	logic [iesl_pkg::REQ_W-1:0]      next_req_seen;
	logic                            request;
	logic                            next_request;
	logic [7:0]                      vector;
	logic [7:0]                      next_vector;

	logic [iesl_pkg::REQ_W-1:0]      permit;
	logic [iesl_pkg::REQ_W-1:0]      pending;
	logic                            enc_found;
	logic [iesl_pkg::IDX_W-1:0]      enc_index;
	logic [iesl_pkg::ADR_W-1:0]      word_adr;
	logic [31:0]                     read_value;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] merge_bytes(
		input logic [15:0] old_value,
		input logic [31:0] wr_data,
		input logic [3:0]  sel
	);
		logic [15:0] res;
		res = old_value;
		if (sel[0]) begin
			res[7:0] = wr_data[7:0];
		end
		if (sel[1]) begin
			res[15:8] = wr_data[15:8];
		end
		return res;
	endfunction

	// ****************************************
	// Request sampling
	// ****************************************
	// Plain sample each cycle: levels only, nothing held once the line drops
	always_comb begin
		next_req_seen = req_i;
		next_req_seen[iesl_pkg::UNUSED_BIT] = 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_seen <= '0;
		end else begin
			req_seen <= next_req_seen;
		end
	end

	// ****************************************
	// Gating and vector selection
	// ****************************************
	always_comb begin
		permit = {source_enable_mid, source_enable_low};
		permit[iesl_pkg::UNUSED_BIT] = 1'b0;
		pending = req_seen & permit;
	end

	iesl_prio_enc #(
		.WIDTH (iesl_pkg::REQ_W),
		.IDX_W (iesl_pkg::IDX_W)
	) u_prio (
		.pending_i (pending),
		.found_o   (enc_found),
		.index_o   (enc_index)
	);

	// No winner reads as the request-0 vector, the documented error value
	always_comb begin
		next_request = enc_found;
		next_vector  = iesl_pkg::VECTOR_BASE + {3'h0, enc_index};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			request <= 1'b0;
			vector  <= iesl_pkg::VECTOR_BASE;
		end else begin
			request <= next_request;
			vector  <= next_vector;
		end
	end

	// ****************************************
	// Read mux
	// ****************************************
	// Low two address bits ignored: each register is one aligned word
	always_comb begin
		word_adr   = {wb_i.adr[iesl_pkg::ADR_W-1:2], 2'b00};
		read_value = 32'h0000_0000;
		case (word_adr)
			iesl_pkg::OFS_ENABLE_LOW: begin
				read_value[15:0] = source_enable_low;
			end
			iesl_pkg::OFS_ACTIVE_LOW: begin
				read_value[15:0] = req_seen[15:0];
			end
			iesl_pkg::OFS_ENABLE_MID: begin
				read_value[15:0] = source_enable_mid;
			end
			iesl_pkg::OFS_ACTIVE_MID: begin
				read_value[15:0] = req_seen[iesl_pkg::MID_BASE +: 16];
			end
			iesl_pkg::OFS_VECTOR: begin
				read_value[7:0] = vector;
				read_value[iesl_pkg::VEC_VALID_BIT] = request;
			end
			default: begin
				read_value = 32'h0000_0000;
			end
		endcase
	end

	// ****************************************
	// Wishbone slave
	// ****************************************
	// One-cycle answer; the ANSWER state swallows the still-held strobe
	always_comb begin
		next_bus_state         = bus_state;
		next_ack               = 1'b0;
		next_rd_data           = 32'h0000_0000;
		next_source_enable_low = source_enable_low;
		next_source_enable_mid = source_enable_mid;
		case (bus_state)
			iesl_pkg::BUS_IDLE: begin
				if (wb_i.cyc && wb_i.stb) begin
					next_ack       = 1'b1;
					next_bus_state = iesl_pkg::BUS_ANSWER;
					if (wb_i.we) begin
						case (word_adr)
							iesl_pkg::OFS_ENABLE_LOW: begin
								next_source_enable_low =
									merge_bytes(source_enable_low, wb_i.dat, wb_i.sel);
							end
							iesl_pkg::OFS_ENABLE_MID: begin
								next_source_enable_mid =
									merge_bytes(source_enable_mid, wb_i.dat, wb_i.sel);
							end
							default: begin
								next_source_enable_low = source_enable_low;
							end
						endcase
					end else begin
						next_rd_data = read_value;
					end
				end
			end
			iesl_pkg::BUS_ANSWER: begin
				next_bus_state = iesl_pkg::BUS_IDLE;
			end
			default: begin
				next_bus_state = iesl_pkg::BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_state         <= iesl_pkg::BUS_IDLE;
			ack               <= 1'b0;
			rd_data           <= 32'h0000_0000;
			source_enable_low <= iesl_pkg::ENABLE_RST;
			source_enable_mid <= iesl_pkg::ENABLE_RST;
		end else begin
			bus_state         <= next_bus_state;
			ack               <= next_ack;
			rd_data           <= next_rd_data;
			source_enable_low <= next_source_enable_low;
			source_enable_mid <= next_source_enable_mid;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign wb_ack_o      = ack;
	assign wb_dat_o      = rd_data;
	assign irq_request_o = request;
	assign irq_vector_o  = vector;

endmodule

// File: bench/iesl_req_src.sv
// Partner model: peripheral sources driving level request lines
`timescale 1ns/100ps
module iesl_req_src (
	input  wire logic        clk_i,
	input  wire logic [31:0] level_i,
	output logic [31:0]      req_o = 32'h00000000
);
	// Levels held until the bench lowers them; never pulsed
	always @(posedge clk_i) begin
		req_o <= level_i;
	end
endmodule

// File: bench/iesl_enable_status_asserts.sv
// Checker: bus and request timing of the enable/status block
`timescale 1ns/100ps
module iesl_es_chk (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire iesl_pkg::iesl_wb_req_s wb_i,
	input wire logic [31:0]            req_i,
	input wire logic                   wb_ack_o,
	input wire logic [31:0]            wb_dat_o,
	input wire logic                   irq_request_o,
	input wire logic [7:0]             irq_vector_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_on_take_a: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_i.cyc) && $past(wb_i.stb))
		else $error("ack without request");
	idle_data_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("data outside ack");
	upper_read_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("upper read bits set");
	status_bit0_zero_a: assert property (wb_ack_o && !$past(wb_i.we) &&
		$past(wb_i.adr) == iesl_pkg::OFS_ACTIVE_LOW |-> !wb_dat_o[0]) else $error("bit 0 set");
	no_winner_base_a: assert property (!irq_request_o |-> irq_vector_o == 8'h10)
		else $error("idle vector wrong");
	winner_was_high_a: assert property (irq_request_o |-> irq_vector_o > 8'h10 &&
		(($past(req_i, 2) >> (irq_vector_o - 8'h10)) & 32'h1) == 32'h1) else $error("bad winner");
	quiet_lines_idle_a: assert property ((req_i[31:1] == 31'h0) [*2] |=> !irq_request_o)
		else $error("request latched");
	cover property (wb_ack_o && $past(wb_i.we));
	cover property (wb_ack_o && !$past(wb_i.we));
	cover property (irq_request_o);
endmodule
bind iesl_enable_status iesl_es_chk u_iesl_es_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
	.req_i(req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_request_o(irq_request_o),
	.irq_vector_o(irq_vector_o));

// File: bench/tb_top.sv
// Testbench: register map, status and vector against a behavioural model
`timescale 1ns/100ps
module tb_top;
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	iesl_pkg::iesl_wb_req_s wb_i  = '0;
	logic [31:0]            level = 32'h0;
	logic [31:0]            req_i, wb_dat_o, rd;
	logic                   wb_ack_o, irq_request_o;
	logic [7:0]             irq_vector_o;
	logic [15:0]            d;
	logic [3:0]             s;
	int                     failures = 0, tests_run = 0;
	int                     en[$] = '{32'hFFFF, 32'hFFFF};
	always #25 clk_i = ~clk_i;
	iesl_req_src u_iesl_req_src (.clk_i(clk_i), .level_i(level), .req_o(req_i));
	iesl_enable_status u_iesl_enable_status (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
		.req_i(req_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
		.irq_request_o(irq_request_o), .irq_vector_o(irq_vector_o));
	task automatic results;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("Error t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Holds the request until ack is seen at an edge, then drops it
	task automatic wb(input logic we, input logic [7:0] a, output logic [31:0] r);
		int n;
		@(posedge clk_i);
		wb_i <= '{1'b1, 1'b1, we, a, s, {16'h0000, d}};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		if (wb_ack_o !== 1'b1) begin
			failures++;
			results();
		end
		r = wb_dat_o;
		wb_i.cyc <= 1'b0;
		wb_i.stb <= 1'b0;
	endtask
	function automatic logic [7:0] vec(input logic [31:0] r);
		logic [31:0] m;
		m = r & {en[1][15:0], en[0][15:0]};
		for (int i = 31; i > 0; i--)
			if (m[i])
				return 8'h10 + 8'(i);
		return 8'h10;
	endfunction
	initial begin
		void'($urandom(32'hA2B0));
		s = 4'h3;
		d = 16'hFFFF;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, iesl_pkg::OFS_ENABLE_LOW, rd); chk(rd, 32'hFFFF);
		wb(1'b0, iesl_pkg::OFS_ENABLE_MID, rd); chk(rd, 32'hFFFF);
		wb(1'b0, 8'h14, rd); chk(rd, 32'h0);
		wb(1'b1, iesl_pkg::OFS_ACTIVE_LOW, rd);
		wb(1'b0, iesl_pkg::OFS_ACTIVE_LOW, rd); chk(rd, 32'h0);
		$display("test reset_map done");
		repeat (30) begin
			for (int k = 0; k < 2; k++) begin
				s = 4'($urandom);
				d = 16'($urandom);
				wb(1'b1, k ? iesl_pkg::OFS_ENABLE_MID : iesl_pkg::OFS_ENABLE_LOW, rd);
				en[k] = {16'h0, s[1] ? d[15:8] : en[k][15:8], s[0] ? d[7:0] : en[k][7:0]};
			end
			level <= $urandom & $urandom & $urandom;
			repeat (4) @(posedge clk_i);
			wb(1'b0, iesl_pkg::OFS_ENABLE_LOW, rd); chk(rd, en[0]);
			wb(1'b0, iesl_pkg::OFS_ENABLE_MID, rd); chk(rd, en[1]);
			wb(1'b0, iesl_pkg::OFS_ACTIVE_LOW, rd); chk(rd, {level[15:1], 1'b0});
			wb(1'b0, iesl_pkg::OFS_ACTIVE_MID, rd); chk(rd, level[31:16]);
			chk(irq_vector_o, vec(level));
			chk(irq_request_o, vec(level) != 8'h10);
		end
		$display("test random_mask done");
		level <= 32'h0;
		repeat (4) @(posedge clk_i);
		chk(irq_request_o, 1'b0);
		$display("test level_drop done");
		results();
	end
endmodule
